/* File: spi_flag_map.vh */
// Purpose: offsets, bit positions and reset values of the serial interface flag logic
// Assumes: byte-wide register port with 4-bit address
// Notes:   shared by the flag logic module, its properties and its bench
`ifndef SPI_FLAG_MAP_VH
`define SPI_FLAG_MAP_VH

// ****************
// register offsets
// ****************
`define OFF_CONTROL_ONE   4'h0
`define OFF_CONTROL_TWO   4'h1
`define OFF_CONTROL_THREE 4'h2
`define OFF_STATUS        4'h3
`define OFF_DATA_HIGH     4'h4
`define OFF_DATA_LOW      4'h5
`define OFF_MATCH_HIGH    4'h6
`define OFF_MATCH_LOW     4'h7
`define OFF_BAUD          4'h8

// ****************
// control_one bits
// ****************
`define C1_RX_FAULT_IE    7
`define C1_SYSTEM_ENABLE  6
`define C1_TX_IE          5
`define C1_MASTER         4
`define C1_POLARITY       3
`define C1_PHASE          2
`define C1_SS_OUT_EN      1
`define C1_LSB_FIRST      0

// ****************
// control_two and control_three bits
// ****************
`define C2_MATCH_IE       7
`define C2_WIDTH          6
`define C2_TX_DMA         5
`define C2_FAULT_FN       4
`define C2_STOP_IN_WAIT   1
`define C3_TX_WATERMARK   5
`define C3_RX_WATERMARK   4
`define C3_CLEAR_MODE     3
`define C3_QUEUE_ENABLE   0

// ****************
// status bits
// ****************
`define S_RX_FULL         7
`define S_MATCH           6
`define S_TX_EMPTY        5
`define S_MODE_FAULT      4
`define S_RX_NEAR_FULL    1
`define S_TX_NEAR_EMPTY   0

// ****************
// reset values, thresholds (bytes), timing
// ****************
`define RST_CONTROL_ONE   8'h04
`define RST_CONTROL_TWO   8'h00
`define RST_CONTROL_THREE 8'h00
`define RST_BYTE          8'h00
`define RST_WORD          16'h0000
`define TX_NEAR_LO        4'h2
`define TX_NEAR_HI        4'h4
`define RX_NEAR_LO        4'h6
`define RX_NEAR_HI        4'h4
`define SCLK_MIN_DIV      8'h02
`define DIV_ONE           8'h01

`endif

/* File: spi_interrupt_flag_logic.v */
// Purpose: flag, interrupt request and wake logic of a byte/halfword serial interface
// Assumes: shifter, pins and queues live outside; all inputs synchronous to clk
// Notes:   register reads answer one cycle after the read strobe
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "spi_flag_map.vh"

// Overview of operation
// - no request unless system enable set
// - receive/fault enable gates full and fault
// - transmit enable gates empty flag only
// - match enable gates match flag only
// - one shared request; flags always pollable
// - master fault aborts, clears master select
// - fault request lasts while fault flag set
// - full flag after whole byte/halfword copied
// - full flag held; later data dropped
// - empty flag after whole value to shifter
// - empty flag held until clearing sequence
// - match on low byte or full halfword
// - transmit near-empty at two/four bytes left
// - receive near-full above six/four bytes
// - near flag clearing set by clear mode
// - wake only slave, no queue, low power
// - copy shifter after wake, then flags
// - fastest serial clock is clk over two
// - control_one bit layout
// - polarity, phase, bit order meanings
// - control_two upper bit layout
// - fault clears: status read, control_one write
// - stop-in-wait halts module clock in wait
module spi_interrupt_flag_logic (
    input  wire        clk,              // module clock
    input  wire        sys_rst,          // synchronous reset, active high
    input  wire        clk_en,           // freezes all state while low
    input  wire [3:0]  reg_addr,         // register offset
    input  wire [7:0]  reg_wdata,        // register write data
    input  wire        reg_wr,           // write strobe
    input  wire        reg_rd,           // read strobe
    output reg  [7:0]  reg_rdata,        // read data, cycle after strobe
    input  wire        rx_end,           // shifter finished a reception
    input  wire [15:0] rx_shift,         // shifter contents at rx_end
    input  wire        tx_taken,         // shifter took the transmit value
    input  wire        ss_in_low,        // slave-select input low
    input  wire        wait_mode,        // processor in wait mode
    input  wire        stop_mode,        // processor in retaining stop mode
    input  wire [3:0]  tx_fifo_level,    // bytes left in transmit queue
    input  wire [3:0]  rx_fifo_level,    // bytes held in receive queue
    output reg         irq,              // shared interrupt request
    output reg         wake_irq,         // wake request pulse
    output reg         abort_xfer,       // abort pulse on mode fault
    output reg  [15:0] tx_word,          // value offered to the shifter
    output reg         tx_word_valid,    // transmit buffer holds a value
    output reg         tx_dma_req,       // transmit DMA request
    output reg         module_clock_run, // module clock generation allowed
    output reg         sclk_tick,        // one pulse per serial clock period
    output reg         master_mode,      // master select in force
    output reg         clk_polarity,     // 0: active-high serial clock
    output reg         clk_phase,        // 1: edge at start of first cycle
    output reg         ss_out_en,        // select output enable
    output reg         lsb_first,        // 0: most significant bit first
    output reg         halfword_mode     // 1: 16-bit transfers
);

    // ****************
    // functions
    // ****************
    function hit;
        input [3:0] addr;
        input [3:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    function match_hit;
        input [15:0] data;
        input        half;
        input [7:0]  mh;
        input [7:0]  ml;
        begin
            if (half) begin
                match_hit = (data == {mh, ml});
            end else begin
                match_hit = (data[7:0] == ml);
            end
        end
    endfunction

    // mode 0 tracks the level; mode 1 is sticky, write-one clears
    function next_near;
        input flag;
        input cond;
        input mode;
        input clr;
        begin
            if (!mode) begin
                next_near = cond;
            end else if (cond) begin
                next_near = 1'b1;
            end else if (clr && flag) begin
                next_near = 1'b0;
            end else begin
                next_near = flag;
            end
        end
    endfunction

    // ****************
    // state
    // ****************
    reg  [7:0]  control_one;
    reg  [7:0]  control_two;
    reg  [7:0]  control_three;
    reg  [7:0]  match_high_byte;
    reg  [7:0]  match_low_byte;
    reg  [7:0]  baud_div;
    reg  [7:0]  tx_high;
    reg  [15:0] rx_buf;
    reg  [15:0] held_shift;
    reg         held_valid;
    reg         rx_full_flag;
    reg         tx_empty_flag;
    reg         match_flag;
    reg         mode_fault_flag;
    reg         tx_fifo_near_empty_flag;
    reg         rx_fifo_near_full_flag;
    reg         arm_rx;
    reg         arm_tx;
    reg         arm_fault;
    reg  [7:0]  div_cnt;

    wire system_enable = control_one[`C1_SYSTEM_ENABLE];
    wire rx_fault_irq_enable = control_one[`C1_RX_FAULT_IE];
    wire tx_irq_enable = control_one[`C1_TX_IE];
    wire master_select = control_one[`C1_MASTER];
    wire match_irq_enable = control_two[`C2_MATCH_IE];
    wire width_select = control_two[`C2_WIDTH];
    wire fault_function_enable = control_two[`C2_FAULT_FN];
    wire stop_in_wait = control_two[`C2_STOP_IN_WAIT];
    wire queue_enable = control_three[`C3_QUEUE_ENABLE];
    wire clear_mode = control_three[`C3_CLEAR_MODE];

    wire wr_c1 = reg_wr && hit(reg_addr, `OFF_CONTROL_ONE);
    wire wr_st = reg_wr && hit(reg_addr, `OFF_STATUS);
    wire wr_dl = reg_wr && hit(reg_addr, `OFF_DATA_LOW);
    wire rd_st = reg_rd && hit(reg_addr, `OFF_STATUS);
    wire rd_dl = reg_rd && hit(reg_addr, `OFF_DATA_LOW);

    // bus clock considered stopped in these modes
    wire low_power = stop_mode || (wait_mode && stop_in_wait);

    // with select output on, the fault feature is off
    wire fault_now = system_enable && master_select && fault_function_enable
                     && !control_one[`C1_SS_OUT_EN] && ss_in_low;

    // a new value reaches the buffer from the hold or directly
    wire copy_held = held_valid && !low_power;
    wire copy_live = rx_end && !low_power && !held_valid;
    wire        copy_go   = copy_held || copy_live;
    wire [15:0] copy_data = copy_held ? held_shift : rx_shift;

    wire tx_near_cond = control_three[`C3_TX_WATERMARK] ?
                        (tx_fifo_level <= `TX_NEAR_HI) :
                        (tx_fifo_level <= `TX_NEAR_LO);
    wire rx_near_cond = control_three[`C3_RX_WATERMARK] ?
                        (rx_fifo_level > `RX_NEAR_HI) :
                        (rx_fifo_level > `RX_NEAR_LO);

    wire [7:0] div_max = (baud_div < `SCLK_MIN_DIV) ? `SCLK_MIN_DIV : baud_div;

    // ****************
    // registers and flags
    // ****************
    always @(posedge clk) begin
        if (sys_rst) begin
            control_one             <= `RST_CONTROL_ONE;
            control_two             <= `RST_CONTROL_TWO;
            control_three           <= `RST_CONTROL_THREE;
            match_high_byte         <= `RST_BYTE;
            match_low_byte          <= `RST_BYTE;
            baud_div                <= `RST_BYTE;
            tx_high                 <= `RST_BYTE;
            tx_word                 <= `RST_WORD;
            tx_word_valid           <= 1'b0;
            rx_buf                  <= `RST_WORD;
            held_shift              <= `RST_WORD;
            held_valid              <= 1'b0;
            rx_full_flag            <= 1'b0;
            tx_empty_flag           <= 1'b1;
            match_flag              <= 1'b0;
            mode_fault_flag         <= 1'b0;
            tx_fifo_near_empty_flag <= 1'b0;
            rx_fifo_near_full_flag  <= 1'b0;
            arm_rx                  <= 1'b0;
            arm_tx                  <= 1'b0;
            arm_fault               <= 1'b0;
            abort_xfer              <= 1'b0;
            wake_irq                <= 1'b0;
        end else if (clk_en) begin
            // configuration writes
            if (wr_c1) begin
                control_one <= reg_wdata;
            end
            if (fault_now) begin
                control_one[`C1_MASTER] <= 1'b0;
            end
            if (reg_wr && hit(reg_addr, `OFF_CONTROL_TWO)) begin
                control_two <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, `OFF_CONTROL_THREE)) begin
                control_three <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, `OFF_MATCH_HIGH) && width_select) begin
                match_high_byte <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, `OFF_MATCH_LOW)) begin
                match_low_byte <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, `OFF_BAUD)) begin
                baud_div <= reg_wdata;
            end

            // status read arms the clearing sequences
            if (rd_st) begin
                arm_rx    <= rx_full_flag;
                arm_tx    <= tx_empty_flag;
                arm_fault <= mode_fault_flag;
            end

            // mode fault: set wins over the clearing write
            abort_xfer <= fault_now;
            if (fault_now) begin
                mode_fault_flag <= 1'b1;
            end else if (wr_c1 && arm_fault) begin
                mode_fault_flag <= 1'b0;
                arm_fault       <= 1'b0;
            end

            // transmit side; low byte write commits the value
            if (reg_wr && hit(reg_addr, `OFF_DATA_HIGH)) begin
                tx_high <= reg_wdata;
            end
            if (wr_dl) begin
                tx_word       <= width_select ? {tx_high, reg_wdata} : {8'h00, reg_wdata};
                tx_word_valid <= 1'b1;
            end else if (tx_taken) begin
                tx_word_valid <= 1'b0;
            end
            if (tx_taken) begin
                tx_empty_flag <= 1'b1;
            end else if (wr_dl && arm_tx) begin
                tx_empty_flag <= 1'b0;
                arm_tx        <= 1'b0;
            end

            // receive side; ended transfers wait out low power
            if (rx_end && (low_power || held_valid)) begin
                held_shift <= rx_shift;
                held_valid <= 1'b1;
            end else if (copy_held) begin
                held_valid <= 1'b0;
            end
            if (copy_go && !rx_full_flag) begin
                if (width_select) begin
                    rx_buf <= copy_data;
                end else begin
                    rx_buf[7:0] <= copy_data[7:0];
                end
            end
            if (copy_go && !rx_full_flag) begin
                rx_full_flag <= 1'b1;
            end else if (rd_dl && arm_rx) begin
                rx_full_flag <= 1'b0;
                arm_rx       <= 1'b0;
            end
            if (copy_go && !rx_full_flag &&
                match_hit(copy_data, width_select, match_high_byte, match_low_byte)) begin
                match_flag <= 1'b1;
            end else if (wr_st && reg_wdata[`S_MATCH]) begin
                match_flag <= 1'b0;
            end

            // queue watermarks; set wins over a write-one clear
            tx_fifo_near_empty_flag <= queue_enable &&
                next_near(tx_fifo_near_empty_flag, tx_near_cond, clear_mode,
                          wr_st && reg_wdata[`S_TX_NEAR_EMPTY]);
            rx_fifo_near_full_flag  <= queue_enable &&
                next_near(rx_fifo_near_full_flag, rx_near_cond, clear_mode,
                          wr_st && reg_wdata[`S_RX_NEAR_FULL]);

            // wake request while the bus clock is stopped
            wake_irq <= rx_end && low_power && rx_fault_irq_enable && system_enable
                        && !master_select && !queue_enable;
        end
    end

    // ****************
    // shared request and mirrored outputs
    // ****************
    always @(posedge clk) begin
        if (sys_rst) begin
            irq              <= 1'b0;
            tx_dma_req       <= 1'b0;
            module_clock_run <= 1'b0;
            master_mode      <= 1'b0;
            clk_polarity     <= 1'b0;
            clk_phase        <= 1'b0;
            ss_out_en        <= 1'b0;
            lsb_first        <= 1'b0;
            halfword_mode    <= 1'b0;
        end else if (clk_en) begin
            // fault request lasts exactly as long as its flag
            irq <= system_enable && (
                   (rx_fault_irq_enable && (rx_full_flag || mode_fault_flag)) ||
                   (tx_irq_enable && tx_empty_flag) ||
                   (match_irq_enable && match_flag));
            tx_dma_req       <= system_enable && control_two[`C2_TX_DMA] && tx_empty_flag;
            module_clock_run <= system_enable && !(wait_mode && stop_in_wait);
            master_mode      <= master_select;
            clk_polarity     <= control_one[`C1_POLARITY];
            clk_phase        <= control_one[`C1_PHASE];
            ss_out_en        <= control_one[`C1_SS_OUT_EN];
            lsb_first        <= control_one[`C1_LSB_FIRST];
            halfword_mode    <= width_select;
        end
    end

    // ****************
    // serial clock period divider
    // ****************
    // divisor floored at two so the serial clock never beats clk/2
    always @(posedge clk) begin
        if (sys_rst) begin
            div_cnt   <= `RST_BYTE;
            sclk_tick <= 1'b0;
        end else if (clk_en) begin
            if (!(system_enable && master_select) || low_power) begin
                div_cnt   <= `RST_BYTE;
                sclk_tick <= 1'b0;
            end else if (div_cnt >= div_max - `DIV_ONE) begin
                div_cnt   <= `RST_BYTE;
                sclk_tick <= 1'b1;
            end else begin
                div_cnt   <= div_cnt + `DIV_ONE;
                sclk_tick <= 1'b0;
            end
        end
    end

    // ****************
    // register read port
    // ****************
    always @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= `RST_BYTE;
        end else if (clk_en) begin
            reg_rdata <= `RST_BYTE;
            if (reg_rd) begin
                case (reg_addr)
                    `OFF_CONTROL_ONE:   reg_rdata <= control_one;
                    `OFF_CONTROL_TWO:   reg_rdata <= control_two;
                    `OFF_CONTROL_THREE: reg_rdata <= control_three;
                    `OFF_STATUS: begin
                        reg_rdata[`S_RX_FULL]       <= rx_full_flag;
                        reg_rdata[`S_MATCH]         <= match_flag;
                        reg_rdata[`S_TX_EMPTY]      <= tx_empty_flag;
                        reg_rdata[`S_MODE_FAULT]    <= mode_fault_flag;
                        reg_rdata[`S_RX_NEAR_FULL]  <= rx_fifo_near_full_flag;
                        reg_rdata[`S_TX_NEAR_EMPTY] <= tx_fifo_near_empty_flag;
                    end
                    `OFF_DATA_HIGH:     reg_rdata <= rx_buf[15:8];
                    `OFF_DATA_LOW:      reg_rdata <= rx_buf[7:0];
                    `OFF_MATCH_HIGH:    reg_rdata <= match_high_byte;
                    `OFF_MATCH_LOW:     reg_rdata <= match_low_byte;
                    `OFF_BAUD:          reg_rdata <= baud_div;
                    default:            reg_rdata <= `RST_BYTE;
                endcase
            end
        end
    end

endmodule // spi_interrupt_flag_logic
`default_nettype wire

/* File: spi_far_end.sv */
// Purpose: far-side shifter model giving receive and take events
// Assumes: one frame per go pulse, lat cycles long, lat at least 1
// Notes:   data lines show a changing pattern outside frames
`timescale 1ns/10ps
`default_nettype none
module spi_far_end (
    input  wire logic        clk,      // clock
    input  wire logic        go,       // start one frame
    input  wire logic [15:0] data,     // value to deliver
    input  wire logic [3:0]  lat,      // frame length
    input  wire logic        tx_valid, // block offers a value
    output logic             rx_end,   // frame over
    output logic      [15:0] rx_shift, // received value
    output logic             tx_taken  // value taken
);
    logic [3:0]  cnt = 4'h0;
    logic [15:0] hold = 16'h0000;
    initial {rx_end, tx_taken, rx_shift} = 18'h00000;
    // value is taken at frame start, so empty comes before full
    always @(posedge clk) begin
        tx_taken <= go && tx_valid;
        rx_end   <= cnt == 4'h1;
        rx_shift <= (cnt == 4'h1) ? hold : ~rx_shift;
        if (go) begin
            hold <= data;
            cnt  <= lat;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule // spi_far_end
`default_nettype wire

/* File: spi_flag_props.sv */
// Purpose: port properties of the flag logic
// Assumes: clk_en held high
// Notes:   control bits shadowed from the register port
`timescale 1ns/10ps
`default_nettype none
`include "spi_flag_map.vh"
module spi_flag_props (
    input wire logic       clk,              // clock
    input wire logic       sys_rst,          // reset
    input wire logic [3:0] reg_addr,         // offset
    input wire logic [7:0] reg_wdata,        // write data
    input wire logic       reg_wr,           // write strobe
    input wire logic       rx_end,           // frame end
    input wire logic       wait_mode,        // wait
    input wire logic       stop_mode,        // stop
    input wire logic       irq,              // request
    input wire logic       wake_irq,         // wake pulse
    input wire logic       abort_xfer,       // abort pulse
    input wire logic       sclk_tick,        // serial tick
    input wire logic       master_mode,      // master copy
    input wire logic       clk_polarity,     // polarity copy
    input wire logic       clk_phase,        // phase copy
    input wire logic       ss_out_en,        // select-out copy
    input wire logic       lsb_first,        // order copy
    input wire logic       halfword_mode,    // width copy
    input wire logic       module_clock_run  // clock gate
);
    logic [7:0] c1q;
    logic [7:0] c2q;
    // shadow misses the fault clear of master; bit unused
    always @(posedge clk) begin
        if (sys_rst) begin
            c1q <= `RST_CONTROL_ONE;
            c2q <= `RST_CONTROL_TWO;
        end else if (reg_wr && reg_addr == `OFF_CONTROL_ONE) begin
            c1q <= reg_wdata;
        end else if (reg_wr && reg_addr == `OFF_CONTROL_TWO) begin
            c2q <= reg_wdata;
        end
    end
    // ****************
    // properties
    // ****************
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence fault_seq;
        abort_xfer ##1 !master_mode;
    endsequence
    irq_off_a: assert property (!$past(c1q[6]) |-> !irq)
        else $error("request while disabled");
    fault_drop_a: assert property (abort_xfer |-> fault_seq)
        else $error("master kept after fault");
    fault_irq_a: assert property (abort_xfer && c1q[7] && c1q[6] |=> irq)
        else $error("no request on fault");
    wake_cause_a: assert property (wake_irq |-> $past(rx_end) && $past(c1q[7])
        && $past(stop_mode || (wait_mode && c2q[1]))) else $error("bad wake");
    tick_space_a: assert property (sclk_tick |=> !sclk_tick)
        else $error("serial clock too fast");
    ctrl_copy_a: assert property (!$past(sys_rst) |->
        {clk_polarity, clk_phase, ss_out_en, lsb_first} == $past(c1q[3:0])) else $error("control copy");
    width_copy_a: assert property (!$past(sys_rst) |-> halfword_mode == $past(c2q[6]))
        else $error("width copy");
    clock_gate_a: assert property (!$past(sys_rst) |->
        module_clock_run == ($past(c1q[6]) && !($past(wait_mode) && $past(c2q[1])))) else $error("clock gate");
endmodule // spi_flag_props
bind spi_interrupt_flag_logic spi_flag_props i_props (.*);
`default_nettype wire

/* File: tb_spi_interrupt_flag_logic.sv */
// Purpose: self-checking bench for the flag logic
// Assumes: clk_en high, queue levels zero until the watermark checks near the end
// Notes:   read data checked against a queue of expectations
`timescale 1ns/10ps
`default_nettype none
`include "spi_flag_map.vh"
module tb_spi_interrupt_flag_logic;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        ss_in_low = 1'b0;
    logic        stop_mode = 1'b0;
    logic        go = 1'b0;
    logic        rdv = 1'b0;
    logic        woke = 1'b0;
    logic [15:0] fdata = 16'h0000;
    logic [3:0]  lat = 4'h1;
    logic [3:0]  lvl = 4'h0;
    logic [7:0]  reg_rdata;
    logic [15:0] rx_shift, tx_word, d;
    logic        rx_end, tx_taken, irq, wake_irq, tx_word_valid, master_mode, dma;
    logic [7:0]  expq[$];
    logic [8:0]  mtab[4] = '{9'h0C1, 9'h080, 9'h040, 9'h180};
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    spi_interrupt_flag_logic i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_end(rx_end),
        .rx_shift(rx_shift), .tx_taken(tx_taken), .ss_in_low(ss_in_low), .wait_mode(stop_mode),
        .stop_mode(stop_mode), .tx_fifo_level(lvl), .rx_fifo_level(lvl), .irq(irq), .wake_irq(wake_irq),
        .abort_xfer(), .tx_word(tx_word), .tx_word_valid(tx_word_valid), .tx_dma_req(dma), .module_clock_run(),
        .sclk_tick(), .master_mode(master_mode), .clk_polarity(), .clk_phase(), .ss_out_en(),
        .lsb_first(), .halfword_mode());
    spi_far_end i_far (.clk(clk), .go(go), .data(fdata), .lat(lat), .tx_valid(tx_word_valid),
        .rx_end(rx_end), .rx_shift(rx_shift), .tx_taken(tx_taken));
    always #25 clk = ~clk;
    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        expq.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic frame(input logic [15:0] v);
        @(posedge clk);
        fdata <= v;
        lat <= 4'h1 + 4'($urandom % 8);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (11) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // read data stand one cycle after the strobe
    always @(posedge clk) begin
        rdv <= reg_rd;
        woke <= woke | wake_irq;
        cyc <= cyc + 1;
        if (rdv) chk(16'(reg_rdata), 16'(expq.pop_front()));
        if (cyc == 4000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'hb1a4));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`OFF_CONTROL_ONE, `RST_CONTROL_ONE);
        rd(`OFF_CONTROL_TWO, `RST_CONTROL_TWO);
        rd(`OFF_STATUS, 8'h20);
        rd(4'h9, 8'h00);
        wr(`OFF_CONTROL_ONE, 8'h4F);
        rd(`OFF_CONTROL_ONE, 8'h4F);
        $display("test registers done");
        foreach (mtab[i]) begin
            wr(`OFF_CONTROL_ONE, mtab[i][8:1]);
            repeat (3) @(posedge clk);
            chk(16'(irq), 16'(mtab[i][0]));
        end
        rd(`OFF_STATUS, 8'h20);
        $display("test masks done");
        for (int h = 0; h < 2; h++) begin
            d = 16'($urandom);
            wr(`OFF_CONTROL_ONE, 8'h40);
            wr(`OFF_CONTROL_TWO, h ? 8'hC0 : 8'h80);
            wr(`OFF_MATCH_HIGH, d[15:8]);
            wr(`OFF_MATCH_LOW, d[7:0]);
            frame(h ? d : {~d[15:8], d[7:0]});
            chk(16'(irq), 16'h0001);
            wr(`OFF_STATUS, 8'h40);
            repeat (3) @(posedge clk);
            chk(16'(irq), 16'h0000);
            frame(~d);
            rd(`OFF_STATUS, 8'hA0);
            if (h) rd(`OFF_DATA_HIGH, d[15:8]);
            rd(`OFF_DATA_LOW, d[7:0]);
            rd(`OFF_STATUS, 8'h20);
        end
        $display("test receive done");
        wr(`OFF_CONTROL_TWO, 8'h72);
        wr(`OFF_CONTROL_ONE, 8'hD0);
        ss_in_low <= 1'b1;
        repeat (3) @(posedge clk);
        ss_in_low <= 1'b0;
        chk(16'(irq), 16'h0001);
        chk(16'(master_mode), 16'h0000);
        chk(16'(dma), 16'h0001);
        rd(`OFF_STATUS, 8'h30);
        wr(`OFF_CONTROL_ONE, 8'hC0);
        repeat (3) @(posedge clk);
        chk(16'(irq), 16'h0000);
        rd(`OFF_STATUS, 8'h20);
        $display("test fault done");
        d = 16'($urandom);
        wr(`OFF_MATCH_LOW, ~d[7:0]);
        stop_mode <= 1'b1;
        frame(d);
        chk(16'(woke), 16'h0001);
        rd(`OFF_STATUS, 8'h20);
        stop_mode <= 1'b0;
        repeat (3) @(posedge clk);
        rd(`OFF_STATUS, 8'hA0);
        rd(`OFF_DATA_LOW, d[7:0]);
        $display("test wake done");
        rd(`OFF_STATUS, 8'h20);
        wr(`OFF_DATA_LOW, 8'h5A);
        rd(`OFF_STATUS, 8'h00);
        chk(tx_word, 16'h005A);
        chk(16'(dma), 16'h0000);
        frame({8'h12, d[7:0]});
        rd(`OFF_STATUS, 8'hA0);
        wr(`OFF_CONTROL_THREE, 8'h39);
        lvl <= 4'h5;
        rd(`OFF_STATUS, 8'hA2);
        lvl <= 4'h3;
        rd(`OFF_STATUS, 8'hA3);
        wr(`OFF_STATUS, 8'h03);
        rd(`OFF_STATUS, 8'hA1);
        repeat (3) @(posedge clk);
        $display("test transmit done");
        wrap_up();
    end
endmodule // tb_spi_interrupt_flag_logic
`default_nettype wire
